//--- core/tcr_pkg.sv
/*
 * Shared constants for the timer control block: register indices, field
 * positions, reset values, source and prescale codes.
 * Assumes a byte-wide register port whose address selects one register.
 */
package tcr_pkg;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;
    localparam int ADDR_W_DEF = 4;

    // Register indices on the register port.
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_CNT_LO = 2'h1;
    localparam logic [1:0] IDX_CNT_HI = 2'h2;

    // Field positions inside timer_control.
    localparam int POS_SRC = 6;
    localparam int POS_PS = 4;
    localparam int POS_OSC_EN = 3;
    localparam int POS_SYNC_N = 2;
    localparam int POS_UNUSED = 1;
    localparam int POS_ON = 0;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;

    // Clock source codes.
    localparam logic [1:0] SRC_INSTR = 2'h0;
    localparam logic [1:0] SRC_SYS = 2'h1;
    localparam logic [1:0] SRC_TOUCH = 2'h2;
    localparam logic [1:0] SRC_EXT = 2'h3;

    // The instruction clock runs at one quarter of the system clock.
    localparam int QUARTER_DIV = 4;
    localparam logic [1:0] PHASE_LAST = 2'(QUARTER_DIV - 1);

    // Count of low-power inputs: touch oscillator, pin, crystal.
    localparam int EXT_IN_W = 3;
    localparam int EXT_TOUCH = 0;
    localparam int EXT_PIN = 1;
    localparam int EXT_XTAL = 2;

    // Prescaler compare value for a division of 1, 2, 4 or 8.
    function automatic logic [2:0] presc_mask(input logic [1:0] ps);
        logic [2:0] m;
        m = 3'h0;
        case (ps)
            2'h0: m = 3'h0;
            2'h1: m = 3'h1;
            2'h2: m = 3'h3;
            default: m = 3'h7;
        endcase
        return m;
    endfunction
endpackage

//--- core/tcr_sync_edge.sv
/*
 * Two-flop synchroniser with rising-edge detection for a group of
 * asynchronous inputs.
 * Assumes the inputs are slow against clk; pulses narrower than one
 * clock period may be lost.
 */
`timescale 1ns/1ps
`default_nettype none
module tcr_sync_edge #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] riseOut
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("tcr_sync_edge needs WIDTH of at least one");
        end
    endgenerate

    // The edge is taken between the second and third stage only.
    assign riseOut = sync_q & ~prev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= asyncIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end
endmodule
`default_nettype wire

//--- core/tcr_timer_ctrl.sv
/*
 * Timer control register with clock source selection, prescaler and a
 * 16-bit count that software can read back.
 * Assumes a single system clock, a synchronous active-low reset and a
 * register port whose strobes last one cycle and never overlap.
 */
// Chosen here: strobed register access and the placing of the registers.
// Notes on behaviour
// R1 - Source 01 system clock, 00 quarter rate
// R2 - External source: pin or crystal by enable
// R3 - Prescale codes divide by 1, 2, 4, 8
// R4 - Sync bit matters only for sources 1X
// R5 - Bit 1 reads zero, ignores writes
// R6 - Bit 0 set lets the timer count
`timescale 1ns/1ps
`default_nettype none
module tcr_timer_ctrl
    import tcr_pkg::*;
#(
    parameter int ADDR_W = tcr_pkg::ADDR_W_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [tcr_pkg::DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [tcr_pkg::DATA_W-1:0] rdData,
    input wire logic ext_count_pin,
    input wire logic crystal_pins,
    input wire logic touch_sense_osc,
    output logic [tcr_pkg::COUNT_W-1:0] countValue,
    output logic rolloverPulse
);
    generate
        if (ADDR_W < 2) begin : g_chk
            $error("tcr_timer_ctrl needs ADDR_W of at least two");
        end
    endgenerate

    logic [1:0] clock_source_select_q;
    logic [1:0] prescale_select_q;
    logic low_power_osc_enable_q;
    logic ext_clock_sync_n_q;
    logic counter_on_q;
    logic [1:0] phase_q;
    logic [2:0] prescCnt_q;
    logic pend_q;
    logic [COUNT_W-1:0] count_q;
    logic [DATA_W-1:0] rdData_q;
    logic roll_q;

    logic [EXT_IN_W-1:0] extRise;
    logic [EXT_IN_W-1:0] extRaw;

    assign extRaw = {crystal_pins, ext_count_pin, touch_sense_osc};

    tcr_sync_edge #(
        .WIDTH(EXT_IN_W)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .asyncIn(extRaw),
        .riseOut(extRise)
    );

    // Address decoding.
    wire hitCtrl = regAddr == ADDR_W'(IDX_CTRL);
    wire hitLo = regAddr == ADDR_W'(IDX_CNT_LO);
    wire hitHi = regAddr == ADDR_W'(IDX_CNT_HI);
    wire wrCtrl = wrStrobe && hitCtrl;

    // R5 - bit one zero
    wire [DATA_W-1:0] ctrlView = {clock_source_select_q, prescale_select_q,
        low_power_osc_enable_q, ext_clock_sync_n_q, 1'b0, counter_on_q};

    wire [DATA_W-1:0] rdMux = hitCtrl ? ctrlView :
        hitLo ? count_q[7:0] :
        hitHi ? count_q[15:8] : 8'h00;

    wire phaseLast = phase_q == PHASE_LAST;

    // R2 - pin or crystal
    wire extEdge = low_power_osc_enable_q ? extRise[EXT_XTAL] :
        extRise[EXT_PIN];
    wire slowEdge = clock_source_select_q == SRC_EXT ? extEdge :
        extRise[EXT_TOUCH];

    // R4 - sync bit use
    // Synchronised mode holds an edge until the next instruction phase,
    // so counts line up with the quarter-rate clock; the free-running
    // mode counts an edge as soon as it leaves the synchroniser.
    wire syncMode = !ext_clock_sync_n_q;
    wire slowTick = syncMode ? (phaseLast && (pend_q || slowEdge)) :
        slowEdge;
    wire pend_d = clock_source_select_q[1] && syncMode &&
        (pend_q || slowEdge) && !phaseLast;

    // R1 - source selection
    wire srcTick = clock_source_select_q == SRC_SYS ? 1'b1 :
        clock_source_select_q == SRC_INSTR ? phaseLast : slowTick;

    // R3 - prescale divide
    wire [2:0] pMask = presc_mask(prescale_select_q);
    wire prescDone = prescCnt_q == pMask;
    // R6 - count when on
    wire incEn = counter_on_q && srcTick && prescDone;
    // A control write restarts the prescaler, so a new division never
    // inherits a part-count left over from the old one.
    wire [2:0] prescCnt_d = (!counter_on_q || wrCtrl) ? 3'h0 :
        !srcTick ? prescCnt_q :
        prescDone ? 3'h0 : prescCnt_q + 3'h1;
    wire [COUNT_W-1:0] count_d = incEn ? count_q + 16'h0001 : count_q;
    wire roll_d = incEn && count_q == 16'hffff;

    assign rdData = rdData_q;
    assign countValue = count_q;
    assign rolloverPulse = roll_q;

    // R5 - write drops bit one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_source_select_q <= CTRL_RESET[POS_SRC +: 2];
            prescale_select_q <= CTRL_RESET[POS_PS +: 2];
            low_power_osc_enable_q <= CTRL_RESET[POS_OSC_EN];
            ext_clock_sync_n_q <= CTRL_RESET[POS_SYNC_N];
            counter_on_q <= CTRL_RESET[POS_ON];
        end else if (wrCtrl) begin
            clock_source_select_q <= wrData[POS_SRC +: 2];
            prescale_select_q <= wrData[POS_PS +: 2];
            low_power_osc_enable_q <= wrData[POS_OSC_EN];
            ext_clock_sync_n_q <= wrData[POS_SYNC_N];
            counter_on_q <= wrData[POS_ON];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_q <= 2'h0;
            prescCnt_q <= 3'h0;
            pend_q <= 1'b0;
            count_q <= COUNT_RESET;
            roll_q <= 1'b0;
        end else begin
            phase_q <= phase_q + 2'h1;
            prescCnt_q <= prescCnt_d;
            pend_q <= pend_d;
            count_q <= count_d;
            roll_q <= roll_d;
        end
    end

    // Read data stand for exactly one cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdData_q <= 8'h00;
        end else if (rdStrobe) begin
            rdData_q <= rdMux;
        end else begin
            rdData_q <= 8'h00;
        end
    end

    property p_sys_clock;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_SYS &&
            prescale_select_q == 2'h0)
        |=> countValue == $past(countValue) + 16'h0001;
    endproperty
    a_sys_clock: assert property (p_sys_clock) // R1
        else $error("system clock source did not count every cycle");

    property p_quarter;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_INSTR &&
            prescale_select_q == 2'h0 && phaseLast)
        |=> countValue == $past(countValue) + 16'h0001;
    endproperty
    a_quarter: assert property (p_quarter) // R1
        else $error("instruction clock did not count once per four");

    property p_ext_pin;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_EXT &&
            !low_power_osc_enable_q && ext_clock_sync_n_q &&
            prescale_select_q == 2'h0)
        |=> countValue == $past(countValue) +
            {15'h0000, $past(extRise[EXT_PIN])};
    endproperty
    a_ext_pin: assert property (p_ext_pin) // R2
        else $error("pin edges not counted one for one");

    property p_ext_xtal;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_EXT &&
            low_power_osc_enable_q && ext_clock_sync_n_q &&
            !extRise[EXT_XTAL])
        |=> $stable(countValue);
    endproperty
    a_ext_xtal: assert property (p_ext_xtal) // R2
        else $error("count moved without a crystal edge");

    property p_presc;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && srcTick)
        |=> countValue == $past(countValue) +
            {15'h0000, $past(prescCnt_q) ==
            presc_mask($past(prescale_select_q))};
    endproperty
    a_presc: assert property (p_presc) // R3
        else $error("prescaler let through the wrong tick");

    property p_sync_phase;
        @(posedge clk) disable iff (!rst_n)
        (clock_source_select_q[1] && !ext_clock_sync_n_q && !phaseLast)
        |=> $stable(countValue);
    endproperty
    a_sync_phase: assert property (p_sync_phase) // R4
        else $error("synchronised count off the instruction phase");

    property p_bit_one;
        @(posedge clk) disable iff (!rst_n)
        (rdStrobe && hitCtrl) |=> rdData[POS_UNUSED] == 1'b0;
    endproperty
    a_bit_one: assert property (p_bit_one) // R5
        else $error("unused control bit read as one");

    property p_off;
        @(posedge clk) disable iff (!rst_n)
        !counter_on_q |=> $stable(countValue) && !rolloverPulse;
    endproperty
    a_off: assert property (p_off) // R6
        else $error("count moved while the timer was off");

    property p_on_write;
        @(posedge clk) disable iff (!rst_n)
        wrCtrl |=> counter_on_q == $past(wrData[POS_ON]);
    endproperty
    a_on_write: assert property (p_on_write) // R6
        else $error("on bit did not follow the write");

    property p_quarter_gap;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_INSTR && !phaseLast)
        |=> $stable(countValue);
    endproperty
    a_quarter_gap: assert property (p_quarter_gap) // R1
        else $error("instruction clock counted off its phase");

    property p_presc_range;
        @(posedge clk) disable iff (!rst_n)
        prescCnt_q <= pMask;
    endproperty
    a_presc_range: assert property (p_presc_range) // R3
        else $error("prescaler ran past its division");

    property p_unsync_ext;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q[1] && ext_clock_sync_n_q &&
            prescale_select_q == 2'h0)
        |=> countValue == $past(countValue) + {15'h0000, $past(slowEdge)};
    endproperty
    a_unsync_ext: assert property (p_unsync_ext) // R4
        else $error("free-running source did not count its edge at once");

    property p_sync_count;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q[1] && !ext_clock_sync_n_q &&
            prescale_select_q == 2'h0 && phaseLast && (pend_q || slowEdge))
        |=> countValue == $past(countValue) + 16'h0001;
    endproperty
    a_sync_count: assert property (p_sync_count) // R4
        else $error("held external edge lost at the instruction phase");

    property p_xtal_count;
        @(posedge clk) disable iff (!rst_n)
        (counter_on_q && clock_source_select_q == SRC_EXT &&
            low_power_osc_enable_q && ext_clock_sync_n_q &&
            prescale_select_q == 2'h0)
        |=> countValue == $past(countValue) +
            {15'h0000, $past(extRise[EXT_XTAL])};
    endproperty
    a_xtal_count: assert property (p_xtal_count) // R2
        else $error("crystal edges not counted one for one");

    property p_read_idle;
        @(posedge clk) disable iff (!rst_n)
        !rdStrobe |=> rdData == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data stood without a read strobe");

    property p_roll;
        @(posedge clk) disable iff (!rst_n)
        (incEn && count_q == 16'hffff)
        |=> rolloverPulse && countValue == 16'h0000;
    endproperty
    a_roll: assert property (p_roll)
        else $error("wrap from all ones gave no rollover pulse");

    property p_on_hold;
        @(posedge clk) disable iff (!rst_n)
        !wrCtrl |=> $stable(counter_on_q);
    endproperty
    a_on_hold: assert property (p_on_hold) // R6
        else $error("on bit moved without a control write");

    c_roll: cover property (@(posedge clk) disable iff (!rst_n)
        rolloverPulse);
    c_sync_ext: cover property (@(posedge clk) disable iff (!rst_n)
        incEn && clock_source_select_q == SRC_EXT && syncMode);
    c_touch: cover property (@(posedge clk) disable iff (!rst_n)
        incEn && clock_source_select_q == SRC_TOUCH);
    c_div8: cover property (@(posedge clk) disable iff (!rst_n)
        incEn && prescale_select_q == 2'h3);
endmodule
`default_nettype wire

//--- dv/tcr_clk_src.sv
/*
 * Model of the slow clock sources outside the timer: count pin, crystal
 * and touch-sense oscillator, each with its own half period in ns.
 * Assumes the bench gates each source with a run line.
 */
`timescale 1ns/1ps
`default_nettype none
module tcr_clk_src #(
    parameter int HALF_PIN = 30,
    parameter int HALF_XTAL = 45,
    parameter int HALF_TOUCH = 35
) (
    input wire logic runPin,
    input wire logic runXtal,
    input wire logic runTouch,
    output logic pinOut,
    output logic xtalOut,
    output logic touchOut
);
    // Sources rest low between frames, so no stray edge reaches the timer.
    initial begin
        pinOut = 1'b0;
        forever begin
            wait (runPin);
            pinOut = 1'b1;
            #(HALF_PIN);
            pinOut = 1'b0;
            #(HALF_PIN);
        end
    end
    initial begin
        xtalOut = 1'b0;
        forever begin
            wait (runXtal);
            xtalOut = 1'b1;
            #(HALF_XTAL);
            xtalOut = 1'b0;
            #(HALF_XTAL);
        end
    end
    initial begin
        touchOut = 1'b0;
        forever begin
            wait (runTouch);
            touchOut = 1'b1;
            #(HALF_TOUCH);
            touchOut = 1'b0;
            #(HALF_TOUCH);
        end
    end
endmodule
`default_nettype wire

//--- dv/tcr_timer_ctrl_bench.sv
/*
 * Self-checking bench for the timer control block: register port,
 * source and prescale selection, on bit and the slow external sources.
 * Assumes the source model in tcr_clk_src and a 200 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tcr_timer_ctrl_bench;
    import tcr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [7:0] wrData = 8'h00;
    logic wrStrobe = 1'b0;
    logic rdStrobe = 1'b0;
    logic [7:0] rdData;
    logic [15:0] countValue;
    logic rolloverPulse, pinWire, xtalWire, touchWire;
    logic runPin = 1'b0;
    logic runXtal = 1'b0;
    logic runTouch = 1'b0;
    int errorCnt = 0;
    int nChecks = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;

    tcr_timer_ctrl u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .rdData(rdData), .ext_count_pin(pinWire), .crystal_pins(xtalWire),
        .touch_sense_osc(touchWire), .countValue(countValue),
        .rolloverPulse(rolloverPulse));
    tcr_clk_src u_src (.runPin(runPin), .runXtal(runXtal),
        .runTouch(runTouch), .pinOut(pinWire), .xtalOut(xtalWire),
        .touchOut(touchWire));

    task automatic finishTest();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            errorCnt++;
            $display("[FAIL] %0t run did not finish in time", $time);
            finishTest();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wrStrobe <= 1'b1;
        regAddr <= a;
        wrData <= d;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rdStrobe <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        d = rdData;
    endtask

    task automatic t_regs();
        logic [7:0] d;
        rd(4'h0, d);
        check(16'(d), 16'(CTRL_RESET), "control after reset");
        rd(4'h5, d);
        check(16'(d), 16'h0000, "unmapped read");
        wr(4'h5, 8'hff);
        wr(4'h1, 8'hff);
        rd(4'h0, d);
        check(16'(d), 16'h0000, "control after stray writes");
        check(countValue, 16'h0000, "count after stray writes");
        wr(4'h0, 8'hbe);
        rd(4'h0, d);
        check(16'(d), 16'h00bc, "unused bit");
        wr(4'h0, 8'h00);
        $display("register test done");
    endtask

    // Every internal source, prescale code and sync bit setting.
    task automatic t_rate();
        logic [15:0] a;
        for (int i = 0; i < 16; i++) begin
            wr(4'h0, {1'b0, i[3], i[1:0], 1'b0, i[2], 2'b01});
            repeat (8) @(posedge clk);
            #1;
            a = countValue;
            repeat (64) @(posedge clk);
            #1;
            check(countValue - a, (i[3] ? 16'd64 : 16'd16) >> i[1:0],
                  "internal rate");
        end
        $display("rate test done");
    endtask

    task automatic t_off();
        logic [15:0] a;
        logic [7:0] d;
        wr(4'h0, 8'h40);
        repeat (4) @(posedge clk);
        #1;
        a = countValue;
        repeat (32) @(posedge clk);
        #1;
        check(countValue, a, "count while off");
        rd(4'h1, d);
        check(16'(d), 16'(a[7:0]), "count low byte");
        rd(4'h2, d);
        check(16'(d), 16'(a[15:8]), "count high byte");
        $display("off test done");
    endtask

    // All three sources run at once; only the selected one may count.
    task automatic t_ext();
        logic [7:0] cfg [6] = '{8'hc5, 8'hc9, 8'h85, 8'hc1, 8'hd5, 8'hcd};
        int half [6] = '{30, 45, 35, 30, 30, 45};
        logic [15:0] a;
        for (int i = 0; i < 6; i++) begin
            wr(4'h0, 8'h00);
            wr(4'h0, cfg[i]);
            repeat (4) @(posedge clk);
            #1;
            a = countValue;
            runPin = 1'b1;
            runXtal = 1'b1;
            runTouch = 1'b1;
            #(20 * half[i] - 1);
            runPin = 1'b0;
            runXtal = 1'b0;
            runTouch = 1'b0;
            repeat (40) @(posedge clk);
            #1;
            check(countValue - a, 16'd10 >> cfg[i][5:4],
                  "external count");
        end
        $display("external test done");
    endtask

    // The count cannot be loaded, so the wrap needs a full pass at the
    // system clock rate; this dominates the run time.
    task automatic t_roll();
        int early = 0;
        wr(4'h0, 8'h41);
        for (int n = 0; n < 70000 && countValue != 16'hffff; n++) begin
            @(posedge clk);
            #1;
            if (rolloverPulse) early++;
        end
        @(posedge clk);
        #1;
        check(countValue, 16'h0000, "count after wrap");
        check(16'(rolloverPulse), 16'h0001, "rollover pulse");
        @(posedge clk);
        #1;
        check(16'(rolloverPulse), 16'h0000, "rollover pulse length");
        check(16'(early), 16'h0000, "early rollover");
        wr(4'h0, 8'h00);
        $display("rollover test done");
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_rate();
        t_off();
        t_ext();
        t_roll();
        finishTest();
    end
endmodule
`default_nettype wire
